// >>> design/adc_cfg_pkg.sv
package adc_cfg_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_TAP_FIRST = 8'hae;
  localparam logic [7:0] IDX_TAP_LAST = 8'hb9;
  localparam logic [7:0] IDX_EDGE_DELAY = 8'hbe;
  localparam logic [7:0] IDX_REF_SELECT = 8'hf0;
  localparam logic [7:0] IDX_UNLOCK = 8'h01;
  localparam logic [7:0] IDX_NOISE_SHIFT = 8'hc0;
  localparam logic [7:0] IDX_STATUS = 8'hc1;
  localparam int TAP_COUNT = 12;
  localparam int TAP_WIDTH = 12;
  localparam int CHANNELS = 8;
  localparam int SAMPLE_WIDTH = 12;
  localparam int PIPE_LATENCY = 12;
  // Field positions
  localparam int TOP_BIT = 15;
  localparam int UNLOCK_BIT = 4;
  localparam int DATA_RISE_LSB = 8;
  localparam int BITCLK_RISE_LSB = 5;
  localparam int DATA_FALL_LSB = 3;
  localparam int BITCLK_FALL_LSB = 0;
  // Reset values, default delays and single-ended detect count
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [1:0] DEF_DATA_DELAY = 2'h0;
  localparam logic [2:0] DEF_BITCLK_DELAY = 3'h0;
  localparam int SE_DETECT_CYCLES = 4;

  typedef struct packed {
    logic [1:0] data_rise;
    logic [2:0] bitclk_rise;
    logic [1:0] data_fall;
    logic [2:0] bitclk_fall;
  } edge_delay_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_state_e;
endpackage

// >>> design/noise_shift_lane.sv
`timescale 1ns/100ps
module noise_shift_lane #(
  parameter int WIDTH = 12
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic [WIDTH-1:0] sample_in,
  output logic [WIDTH-1:0] sample_out
);
  // Alternating sign moves the band near zero to half the sample rate
  logic phase;
  wire logic [WIDTH-1:0] negated = WIDTH'(~sample_in + 1'b1);
  wire logic [WIDTH-1:0] shifted = phase ? negated : sample_in;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      phase <= 1'b0;
      sample_out <= '0;
    end else begin
      phase <= ~phase;
      sample_out <= enable_in ? shifted : sample_in; // [RULE14]
    end
  end
endmodule

// >>> design/sample_pipeline.sv
`timescale 1ns/100ps
module sample_pipeline #(
  parameter int WIDTH = 96,
  parameter int DEPTH = 12
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] data_in,
  output logic [WIDTH-1:0] data_out
);
  logic [WIDTH-1:0] stage [DEPTH];

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage[i] <= '0;
      end
    end else begin
      stage[0] <= data_in;
      for (int i = 1; i < DEPTH; i++) begin
        stage[i] <= stage[i-1]; // [RULE11]
      end
    end
  end

  assign data_out = stage[DEPTH-1];
endmodule

// >>> design/adc_upper_config_registers.sv
// Function
// [RULE1] Twelve 16-bit channel 8 tap registers
// [RULE2] Top tap bit selects user taps
// [RULE3] Software writes zeros to unused bits
// [RULE4] Edge delays apply only when enabled
// [RULE5] Data-lane rise 9:8, fall 4:3
// [RULE6] Bit-clock rise 7:5, fall 2:0
// [RULE7] Reference register needs upper-map unlock bit
// [RULE8] Reference top bit selects outside reference
// [RULE9] Outside reference powers down internal amplifiers
// [RULE10] All channels sampled together each edge
// [RULE11] Output appears twelve cycles after sampling
// [RULE12] Single-ended clock auto-detected, bias off
// [RULE13] Noise shifting enabled per channel
// [RULE14] Shift band near zero to half-rate
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/100ps
module adc_upper_config_registers #(
  parameter int CH = adc_cfg_pkg::CHANNELS,
  parameter int SW = adc_cfg_pkg::SAMPLE_WIDTH
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [9:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Converter data
  input wire logic [CH*SW-1:0] samples_in,
  output logic [CH*SW-1:0] samples_out,
  // Clock-input pin sense
  input wire logic clk_neg_pin_low_in,
  output logic clk_bias_enable_out,
  // Filter and link control
  output logic user_taps_select_ch8_out,
  output logic [adc_cfg_pkg::TAP_COUNT*adc_cfg_pkg::TAP_WIDTH-1:0] tap_value_ch8_out,
  output adc_cfg_pkg::edge_delay_s edge_delay_out,
  // Reference control
  output logic outside_reference_select_out,
  output logic ref_amp_enable_out
);
  logic [15:0] tap_reg [adc_cfg_pkg::TAP_COUNT];
  logic [15:0] edge_reg;
  logic [15:0] ref_reg;
  logic [15:0] unlock_reg;
  logic [CH-1:0] lowfreq_noise_shift_ch;
  logic [CH*SW-1:0] sampled;
  logic [CH*SW-1:0] shifted;
  logic [CH*SW-1:0] pipe_out;
  logic [SW-1:0] lane_out [CH];
  logic se_sync1;
  logic se_sync2;
  logic [2:0] se_count;
  logic single_ended;
  adc_cfg_pkg::bus_state_e state;

  // Address decode
  wire logic [7:0] idx = wb_adr_in[9:2];
  wire logic req = wb_cyc_in && wb_stb_in && state == adc_cfg_pkg::BUS_IDLE;
  wire logic wr = req && wb_we_in;
  wire logic in_taps = idx >= adc_cfg_pkg::IDX_TAP_FIRST && idx <= adc_cfg_pkg::IDX_TAP_LAST;
  wire logic [3:0] tap_sel = 4'(idx - adc_cfg_pkg::IDX_TAP_FIRST);
  wire logic unlocked = unlock_reg[adc_cfg_pkg::UNLOCK_BIT];
  wire logic hit_ref = idx == adc_cfg_pkg::IDX_REF_SELECT && unlocked; // [RULE7]

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = d[7:0];
    end
    if (sel[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (in_taps) begin
      rd_mux = tap_reg[tap_sel];
    end else begin
      case (idx)
        adc_cfg_pkg::IDX_EDGE_DELAY: rd_mux = edge_reg;
        adc_cfg_pkg::IDX_UNLOCK: rd_mux = unlock_reg;
        adc_cfg_pkg::IDX_NOISE_SHIFT: rd_mux = {8'h00, lowfreq_noise_shift_ch};
        adc_cfg_pkg::IDX_STATUS: rd_mux = {15'h0000, single_ended};
        adc_cfg_pkg::IDX_REF_SELECT: rd_mux = hit_ref ? ref_reg : 16'h0000; // [RULE7]
        default: rd_mux = 16'h0000;
      endcase
    end
  end

  // Bus handshake: ack one cycle after request; no request is taken in the ack cycle
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state <= adc_cfg_pkg::BUS_IDLE;
      wb_ack_out <= 1'b0;
      wb_dat_out <= '0;
    end else begin
      case (state)
        adc_cfg_pkg::BUS_IDLE: begin
          wb_ack_out <= req;
          wb_dat_out <= {16'h0000, rd_mux};
          if (req) begin
            state <= adc_cfg_pkg::BUS_ACK;
          end
        end
        adc_cfg_pkg::BUS_ACK: begin
          wb_ack_out <= 1'b0;
          state <= adc_cfg_pkg::BUS_IDLE;
        end
        default: begin
          wb_ack_out <= 1'b0;
          state <= adc_cfg_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Register writes; unused bits stored as written except bits 15:8 of the noise-shift register, software keeps them zero
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < adc_cfg_pkg::TAP_COUNT; i++) begin
        tap_reg[i] <= adc_cfg_pkg::RST_REG;
      end
      edge_reg <= adc_cfg_pkg::RST_REG;
      ref_reg <= adc_cfg_pkg::RST_REG;
      unlock_reg <= adc_cfg_pkg::RST_REG;
      lowfreq_noise_shift_ch <= '0;
    end else if (wr) begin
      if (in_taps) begin
        tap_reg[tap_sel] <= merge(tap_reg[tap_sel], wb_dat_in, wb_sel_in); // [RULE1]
      end
      if (idx == adc_cfg_pkg::IDX_EDGE_DELAY) begin
        edge_reg <= merge(edge_reg, wb_dat_in, wb_sel_in);
      end
      if (hit_ref) begin
        ref_reg <= merge(ref_reg, wb_dat_in, wb_sel_in); // [RULE7]
      end
      if (idx == adc_cfg_pkg::IDX_UNLOCK) begin
        unlock_reg <= merge(unlock_reg, wb_dat_in, wb_sel_in);
      end
      if (idx == adc_cfg_pkg::IDX_NOISE_SHIFT && wb_sel_in[0]) begin
        lowfreq_noise_shift_ch <= wb_dat_in[CH-1:0]; // [RULE13]
      end
    end
  end

  // Control outputs, all registered
  wire logic edge_en = edge_reg[adc_cfg_pkg::TOP_BIT];
  wire logic [1:0] dr = edge_reg[adc_cfg_pkg::DATA_RISE_LSB +: 2]; // [RULE5]
  wire logic [1:0] df = edge_reg[adc_cfg_pkg::DATA_FALL_LSB +: 2]; // [RULE5]
  wire logic [2:0] cr = edge_reg[adc_cfg_pkg::BITCLK_RISE_LSB +: 3]; // [RULE6]
  wire logic [2:0] cf = edge_reg[adc_cfg_pkg::BITCLK_FALL_LSB +: 3]; // [RULE6]
  logic [adc_cfg_pkg::TAP_COUNT*adc_cfg_pkg::TAP_WIDTH-1:0] tap_flat;
  always_comb begin
    for (int i = 0; i < adc_cfg_pkg::TAP_COUNT; i++) begin
      tap_flat[i*adc_cfg_pkg::TAP_WIDTH +: adc_cfg_pkg::TAP_WIDTH] =
        tap_reg[i][adc_cfg_pkg::TAP_WIDTH-1:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      user_taps_select_ch8_out <= 1'b0;
      tap_value_ch8_out <= '0;
      edge_delay_out <= '0;
      outside_reference_select_out <= 1'b0;
      ref_amp_enable_out <= 1'b1;
    end else begin
      // Select bit of the first tap register governs the whole bank
      user_taps_select_ch8_out <= tap_reg[0][adc_cfg_pkg::TOP_BIT]; // [RULE2]
      tap_value_ch8_out <= tap_flat; // [RULE1]
      if (edge_en) begin
        edge_delay_out <= '{dr, cr, df, cf}; // [RULE4]
      end else begin
        edge_delay_out <= '{adc_cfg_pkg::DEF_DATA_DELAY, adc_cfg_pkg::DEF_BITCLK_DELAY,
                            adc_cfg_pkg::DEF_DATA_DELAY, adc_cfg_pkg::DEF_BITCLK_DELAY};
      end
      outside_reference_select_out <= ref_reg[adc_cfg_pkg::TOP_BIT]; // [RULE8]
      ref_amp_enable_out <= ~ref_reg[adc_cfg_pkg::TOP_BIT]; // [RULE9]
    end
  end

  // Single-ended clock detect: negative pin held low for several cycles
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      se_sync1 <= 1'b0;
      se_sync2 <= 1'b0;
      se_count <= 3'h0;
      single_ended <= 1'b0;
      clk_bias_enable_out <= 1'b1;
    end else begin
      se_sync1 <= clk_neg_pin_low_in;
      se_sync2 <= se_sync1;
      if (!se_sync2) begin
        se_count <= 3'h0;
      end else if (se_count != 3'(adc_cfg_pkg::SE_DETECT_CYCLES)) begin
        se_count <= se_count + 3'h1;
      end
      single_ended <= se_count == 3'(adc_cfg_pkg::SE_DETECT_CYCLES); // [RULE12]
      clk_bias_enable_out <= ~single_ended; // [RULE12]
    end
  end

  // All channels captured on the same edge
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sampled <= '0;
    end else begin
      sampled <= samples_in; // [RULE10]
    end
  end

  for (genvar c = 0; c < CH; c++) begin : g_lane
    noise_shift_lane #(.WIDTH(SW)) u_lane (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .enable_in(lowfreq_noise_shift_ch[c]), // [RULE13]
      .sample_in(sampled[c*SW +: SW]),
      .sample_out(lane_out[c])
    );
    assign shifted[c*SW +: SW] = lane_out[c];
  end

  // Capture, shift and output stages complete the total latency
  sample_pipeline #(.WIDTH(CH*SW), .DEPTH(adc_cfg_pkg::PIPE_LATENCY - 3)) u_pipe (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .data_in(shifted),
    .data_out(pipe_out)
  );

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      samples_out <= '0;
    end else begin
      samples_out <= pipe_out; // [RULE11]
    end
  end
endmodule

// >>> verification/adc_cfg_checker_assertions.sv
`timescale 1ns/100ps
module adc_cfg_checker_assertions (
  // Clock and bus
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [9:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  // Controls
  input wire logic clk_neg_pin_low_in,
  input wire logic clk_bias_enable_out,
  input wire logic user_taps_select_ch8_out,
  input wire adc_cfg_pkg::edge_delay_s edge_delay_out,
  input wire logic outside_reference_select_out,
  input wire logic ref_amp_enable_out
);
  logic unlock;
  wire take = wb_cyc_in && wb_stb_in && !wb_ack_out;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence wr(logic [7:0] idx, logic gate);
    gate && take && wb_we_in && wb_sel_in == 4'h3 && wb_adr_in == {idx, 2'b00} ##1 wb_ack_out;
  endsequence
  // Shadow of the gate bit so reference checks know whether access is open
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      unlock <= 1'b0;
    end else if (take && wb_we_in && wb_adr_in == 10'h004) begin
      unlock <= wb_dat_in[4];
    end
  end
  AST_ACK_NEXT: assert property (take |=> wb_ack_out)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  AST_UPPER_ZERO: assert property (wb_ack_out |-> wb_dat_out[31:16] == 16'h0000)
    else $error("upper read half not zero");
  AST_TAP_SELECT: assert property (wr(8'hae, 1'b1) |=>
    user_taps_select_ch8_out == $past(wb_dat_in[15], 2))
    else $error("tap select does not follow top bit");
  AST_EDGE_FIELDS: assert property (wr(8'hbe, 1'b1) |=>
    edge_delay_out == ($past(wb_dat_in[15], 2) ? $past(wb_dat_in[9:0], 2) : 10'h000))
    else $error("edge delay fields wrong");
  AST_REF_OPEN: assert property (wr(8'hf0, unlock) |=>
    outside_reference_select_out == $past(wb_dat_in[15], 2))
    else $error("reference select not written");
  AST_REF_SHUT: assert property (wr(8'hf0, !unlock) |=>
    outside_reference_select_out == $past(outside_reference_select_out, 2))
    else $error("locked reference register changed");
  AST_REF_READ_SHUT: assert property (!unlock && take && !wb_we_in && wb_adr_in == 10'h3c0 |=>
    wb_dat_out == 32'h0)
    else $error("locked reference register readable");
  AST_REF_AMP: assert property (ref_amp_enable_out == !outside_reference_select_out)
    else $error("reference amplifiers not off in outside mode");
  AST_SE_BIAS: assert property (clk_neg_pin_low_in [*8] ##1 clk_neg_pin_low_in [*2] |->
    !clk_bias_enable_out)
    else $error("clock bias still on");
endmodule

// >>> verification/adc_upper_config_registers_tb.sv
`timescale 1ns/100ps
module adc_upper_config_registers_tb;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wb_cyc_in = 1'b0;
  logic wb_stb_in = 1'b0;
  logic wb_we_in = 1'b0;
  logic [9:0] wb_adr_in = 10'h000;
  logic [3:0] wb_sel_in = 4'h3;
  logic [31:0] wb_dat_in = 32'h0;
  logic [95:0] samples_in = 96'h0;
  logic clk_neg_pin_low_in = 1'b0;
  logic [31:0] wb_dat_out;
  logic wb_ack_out;
  logic [95:0] samples_out;
  logic clk_bias_enable_out;
  logic user_taps_select_ch8_out;
  logic [143:0] tap_value_ch8_out;
  adc_cfg_pkg::edge_delay_s edge_delay_out;
  logic outside_reference_select_out;
  logic ref_amp_enable_out;
  int n_mismatch = 0;
  int n_compared = 0;
  int k = 0;
  logic [31:0] q;
  logic [95:0] e;
  logic neg_a;
  adc_upper_config_registers DUT (.mclk_in, .rst_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
    .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .samples_in, .samples_out,
    .clk_neg_pin_low_in, .clk_bias_enable_out, .user_taps_select_ch8_out, .tap_value_ch8_out,
    .edge_delay_out, .outside_reference_select_out, .ref_amp_enable_out);
  // Distinct nonzero value per channel and cycle; never 800h, so negation is visible
  function automatic logic [95:0] pat(input int n);
    for (int c = 0; c < 8; c++) begin
      pat[12*c +: 12] = 12'(n * 16 + c + 1);
    end
  endfunction
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic we, input logic [7:0] idx, input logic [15:0] d);
    @(posedge mclk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= {idx, 2'b00};
    wb_dat_in <= {16'h0000, d};
    do @(posedge mclk_in); while (wb_ack_out !== 1'b1);
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    samples_in <= pat(k);
    k <= k + 1;
  end
  initial begin
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    #1;
    check(ref_amp_enable_out, 1'b1);
    check(clk_bias_enable_out, 1'b1);
    check(edge_delay_out, 10'h000);
    check(outside_reference_select_out, 1'b0);
    for (int n = 0; n < 12; n++) begin
      xfer(1'b1, 8'hae + 8'(n), {n == 0, 3'h0, 12'h5a0 + 12'(n)});
    end
    for (int n = 0; n < 12; n++) begin
      xfer(1'b0, 8'hae + 8'(n), 16'h0000);
      check(q, {16'h0, n == 0, 3'h0, 12'h5a0 + 12'(n)});
      check(tap_value_ch8_out[12*n +: 12], 12'h5a0 + 12'(n));
    end
    check(user_taps_select_ch8_out, 1'b1);
    xfer(1'b1, 8'hae, 16'h05a0);
    xfer(1'b0, 8'h20, 16'h0000);
    check(q, 32'h0);
    check(user_taps_select_ch8_out, 1'b0);
    xfer(1'b1, 8'hbe, 16'h82ae);
    xfer(1'b0, 8'hbe, 16'h0000);
    check(q, 32'h82ae);
    check(edge_delay_out, 10'h2ae);
    xfer(1'b1, 8'hbe, 16'h02ae);
    xfer(1'b0, 8'h20, 16'h0000);
    check(edge_delay_out, 10'h000);
    xfer(1'b1, 8'hf0, 16'h8000);
    xfer(1'b0, 8'hf0, 16'h0000);
    check(q, 32'h0);
    check(outside_reference_select_out, 1'b0);
    xfer(1'b1, 8'h01, 16'h0010);
    xfer(1'b1, 8'hf0, 16'h8000);
    xfer(1'b0, 8'hf0, 16'h0000);
    check(q, 32'h8000);
    check(ref_amp_enable_out, 1'b0);
    #1;
    check(samples_out, pat(k - 13));
    xfer(1'b1, 8'hc0, 16'h0001);
    repeat (16) @(posedge mclk_in);
    #1;
    e = pat(k - 13);
    neg_a = (samples_out[11:0] === -e[11:0]);
    check(samples_out[95:12], e[95:12]);
    @(posedge mclk_in);
    #1;
    e = pat(k - 13);
    check(neg_a ^ (samples_out[11:0] === -e[11:0]), 1'b1);
    @(posedge mclk_in);
    clk_neg_pin_low_in <= 1'b1;
    repeat (12) @(posedge mclk_in);
    #1;
    check(clk_bias_enable_out, 1'b0);
    xfer(1'b0, 8'hc1, 16'h0000);
    check(q[0], 1'b1);
    stop_test();
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk_in);
    n_mismatch++;
    stop_test();
  end
endmodule
bind adc_upper_config_registers adc_cfg_checker_assertions CHK (.mclk_in, .rst_n_in, .wb_cyc_in,
  .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
  .clk_neg_pin_low_in, .clk_bias_enable_out, .user_taps_select_ch8_out, .edge_delay_out,
  .outside_reference_select_out, .ref_amp_enable_out);
